// ---- logic/uart_chan_cfg.svh ----
`ifndef UART_CHAN_CFG_SVH
`define UART_CHAN_CFG_SVH
// Register word indices; byte address is four times the index
`define UC_IDX_CTRL 14'h0884
`define UC_IDX_EVENT 14'h0888
`define UC_IDX_MASK 14'h088a
`define UC_IDX_STATUS 14'h088c
`define UC_IDX_PRAM 14'h0900
`define UC_IDX_BD 14'h0940
// Parameter memory words
`define UC_PW_FCODE 5'd0
`define UC_PW_MRBL 5'd1
`define UC_PW_IDLE 5'd14
`define UC_PW_BRK 5'd15
`define UC_PW_PARC 5'd16
`define UC_PW_FRMC 5'd17
`define UC_PW_NOISEC 5'd18
`define UC_PW_BRKC 5'd19
`define UC_PW_ADDRA 5'd20
`define UC_PW_ADDRB 5'd21
`define UC_PW_RECEIVED_CONTROL_CHARACTER 5'd22
`define UC_PW_CHAR1 5'd23
`define UC_PW_OOS 5'd30
// Control register bits
`define UC_CTL_ENT 0
`define UC_CTL_ENR 1
`define UC_CTL_AUTOMD 2
`define UC_CTL_CL8 3
// Event bits
`define UC_EV_RX 0
`define UC_EV_TX 1
`define UC_EV_BSY 2
`define UC_EV_CCR 3
`define UC_EV_BRK 4
`define UC_EV_IDL 5
`define UC_EV_CD 6
`define UC_EV_CTS 7
// Control-table entry bits
`define UC_CC_END 15
`define UC_CC_REJ 14
`define UC_CC_REA 13
`define UC_CC_INT 12
`define UC_CC_CT 11
`define UC_CC_ADR 8
// Receive descriptor control word bits
`define UC_BD_E 15
`define UC_BD_X 14
`define UC_BD_W 13
`define UC_BD_I 12
`define UC_BD_C 11
`define UC_BD_A 10
`define UC_BD_M 9
`define UC_BD_ID 8
`define UC_BD_BR 5
`define UC_BD_FR 4
`define UC_BD_PR 3
`define UC_BD_OV 1
`define UC_BD_CD 0
`endif

// ---- logic/uart_chan_pkg.sv ----
`default_nettype none
package uart_chan_pkg;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic isAddr;
		logic parityErr;
		logic frameErr;
		logic noise;
		logic brk;
		logic overrun;
	} rx_char_t;
	typedef struct packed {
		logic valid;
		logic extMem;
		logic [31:0] addr;
		logic [7:0] data;
	} buf_wr_t;
	typedef struct packed {
		logic valid;
		logic addrBit;
		logic [7:0] data;
	} oos_req_t;
	typedef struct packed {
		logic go;
		logic [13:0] idx;
		logic [15:0] data;
		logic [1:0] strb;
	} bus_wr_t;
	typedef enum logic [1:0] {
		OOS_IDLE = 2'b01,
		OOS_SEND = 2'b10
	} oos_state_t;
endpackage
`default_nettype wire

// ---- logic/line_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module line_sync #(
	parameter int W = 2
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] level
);
	generate
		if (W < 1) begin : g_chk
			$error("line_sync needs W >= 1");
		end
	endgenerate
	logic [W-1:0] s1_ff, s2_ff, s3_ff, level_ff;
	// Three stages; a change counts once stages two and three agree
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff <= '1;
			s2_ff <= '1;
			s3_ff <= '1;
			level_ff <= '1;
		end else begin
			s1_ff <= pinIn;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			// Follow stage two once three agrees, otherwise keep the old level
			level_ff <= (s2_ff & s3_ff) | (level_ff & (s2_ff ^ s3_ff));
		end
	end
	assign level = level_ff;
endmodule // line_sync
`default_nettype wire

// ---- logic/axil_slave_port.sv ----
`timescale 1ns/100ps
`default_nettype none
module axil_slave_port import uart_chan_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [15:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [15:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	output bus_wr_t wr,
	input wire logic wrHit,
	output logic [13:0] rdIdx,
	input wire logic [15:0] rdData,
	input wire logic rdHit
);
	logic awHeld_ff, wHeld_ff, bvalid_ff, rvalid_ff;
	logic [13:0] awIdx_ff;
	logic [15:0] wData_ff;
	logic [1:0] wStrb_ff, bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	wire awTake = s_awvalid & s_awready;
	wire wTake = s_wvalid & s_wready;
	wire arTake = s_arvalid & s_arready;
	// Address and data may arrive in either order
	assign wr.go = awHeld_ff & wHeld_ff & ~bvalid_ff;
	assign wr.idx = awIdx_ff;
	assign wr.data = wData_ff;
	assign wr.strb = wStrb_ff;
	assign rdIdx = s_araddr[15:2];
	assign s_awready = ~awHeld_ff & ~bvalid_ff;
	assign s_wready = ~wHeld_ff & ~bvalid_ff;
	assign s_arready = ~rvalid_ff;
	// Write channel state
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			awHeld_ff <= 1'b0;
			wHeld_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			awIdx_ff <= 14'h0000;
			wData_ff <= 16'h0000;
			wStrb_ff <= 2'h0;
			bresp_ff <= 2'h0;
		end else begin
			if (awTake) awIdx_ff <= s_awaddr[15:2];
			if (wTake) wData_ff <= s_wdata[15:0];
			if (wTake) wStrb_ff <= s_wstrb[1:0];
			awHeld_ff <= (awHeld_ff | awTake) & ~wr.go;
			wHeld_ff <= (wHeld_ff | wTake) & ~wr.go;
			if (wr.go) bresp_ff <= wrHit ? 2'h0 : 2'h2;
			bvalid_ff <= wr.go | (bvalid_ff & ~s_bready);
		end
	end
	// Read channel: answer one cycle after the address is taken
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= 2'h0;
		end else begin
			if (arTake) rdata_ff <= {16'h0000, rdData};
			if (arTake) rresp_ff <= rdHit ? 2'h0 : 2'h2;
			rvalid_ff <= arTake | (rvalid_ff & ~s_rready);
		end
	end
	assign s_bvalid = bvalid_ff;
	assign s_bresp = bresp_ff;
	assign s_rvalid = rvalid_ff;
	assign s_rdata = rdata_ff;
	assign s_rresp = rresp_ff;
endmodule // axil_slave_port
`default_nettype wire

// ---- logic/uart_channel.sv ----
// Function
// - Discarded character without buffer sets busy event
// - Sent buffer with interrupt bit sets TX
// - Closed buffer with interrupt bit sets RX
// - Mask bits gate events onto interrupt
// - With receiver enabled, status bit two shows carrier or line idle, bit one carrier
// - With transmitter enabled, status bit zero shows clear-to-send negated
// - Thirty-two word parameter memory per channel
// - Maximum length caps every receive buffer
// - Idle characters reaching maximum close buffer
// - Stop command sends programmed break count
// - Parity and framing errors bump counters
// - Noise and break detections bump counters
// - Two multidrop addresses checked on address
// - Rejected control character stored, event raised
// - Entry has character and end flag
// - Non-rejected control character closes buffer
// - Eighth entry sends out-of-sequence character
// - Out-of-sequence send reports event, loss, address
// - Eight four-word receive descriptors
// - Device clears empty, sets status on close
// - Empty, external and wrap bits steer reception
// - Event bits cleared by writing one
// - Stored rejected character sets control event
`timescale 1ns/100ps
`default_nettype none
`include "uart_chan_cfg.svh"
module uart_channel import uart_chan_pkg::*; #(
	parameter int BD_W = 3
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [15:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [15:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	input wire logic cdPin_n,
	input wire logic ctsPin_n,
	input wire rx_char_t rxChar,
	input wire logic rxIdleChar,
	input wire logic rxLineIdle,
	input wire logic txBufDone,
	input wire logic txBufIrq,
	input wire logic stopTxCmd,
	input wire logic oosSent,
	output buf_wr_t bufWr,
	output oos_req_t oosReq,
	output logic breakReq,
	output logic [15:0] breakCount,
	output logic [2:0] rxFuncCode,
	output logic [2:0] txFuncCode,
	output logic irqReq
);
	localparam int NBD = 1 << BD_W;
	generate
		if (BD_W < 1 || BD_W > 3) begin : g_chk
			$error("uart_channel supports 2 to 8 descriptors");
		end
	endgenerate

	// ----------------------------------------
	// Bus slave and pin synchronisers
	// ----------------------------------------
	bus_wr_t wr;
	logic wrHit, rdHit;
	logic [13:0] rdIdx;
	logic [15:0] rdData;
	logic [1:0] lineLvl;
	axil_slave_port u_bus (
		.clk_sys(clk_sys), .rst_n(rst_n),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
		.s_rvalid(s_rvalid), .s_rready(s_rready), .wr(wr), .wrHit(wrHit),
		.rdIdx(rdIdx), .rdData(rdData), .rdHit(rdHit)
	);
	line_sync #(.W(2)) u_sync (
		.clk_sys(clk_sys), .rst_n(rst_n),
		.pinIn({cdPin_n, ctsPin_n}), .level(lineLvl)
	);
	wire cdN = lineLvl[1];
	wire ctsN = lineLvl[0];

	// ----------------------------------------
	// State
	// ----------------------------------------
	// parameter memory
	logic [15:0] pram_ff [32];
	logic [15:0] nxt_pram [32];
	logic [15:0] bd_ff [4*NBD];
	logic [15:0] nxt_bd [4*NBD];
	logic [7:0] evt_ff, nxt_evt, mask_ff, nxt_mask;
	logic [3:0] ctrl_ff, nxt_ctrl;
	logic [BD_W-1:0] bdIdx_ff, nxt_bdIdx;
	logic [15:0] len_ff, nxt_len, idle_ff, nxt_idle;
	logic [11:0] acc_ff, nxt_acc;
	logic hunt_ff, nxt_hunt, oosLost_ff, nxt_oosLost;
	logic cdPrev_ff, ctsPrev_ff, idlPrev_ff;
	oos_state_t oos_ff, nxt_oos;
	buf_wr_t bufWr_ff, nxt_bufWr;
	logic breakReq_ff, irq_ff;
	logic [15:0] breakCnt_ff;
	logic [2:0] rxFc_ff, txFc_ff;

	// ----------------------------------------
	// Decoding
	// ----------------------------------------
	wire receiver_enable_bit = ctrl_ff[`UC_CTL_ENR];
	wire transmitter_enable_bit = ctrl_ff[`UC_CTL_ENT];
	wire [15:0] laneMask = {{8{wr.strb[1]}}, {8{wr.strb[0]}}};
	wire wrPram = wr.idx[13:5] == `UC_IDX_PRAM >> 5;
	wire wrBd = wr.idx[13:BD_W+2] == (`UC_IDX_BD >> (BD_W + 2));
	wire rdPram = rdIdx[13:5] == `UC_IDX_PRAM >> 5;
	wire rdBd = rdIdx[13:BD_W+2] == (`UC_IDX_BD >> (BD_W + 2));
	assign wrHit = wrPram | wrBd | wr.idx == `UC_IDX_CTRL | wr.idx == `UC_IDX_EVENT
		| wr.idx == `UC_IDX_MASK | wr.idx == `UC_IDX_STATUS;
	assign rdHit = rdPram | rdBd | rdIdx == `UC_IDX_CTRL | rdIdx == `UC_IDX_EVENT
		| rdIdx == `UC_IDX_MASK | rdIdx == `UC_IDX_STATUS;
	wire [7:0] statusView = {5'h00, receiver_enable_bit & (cdN | rxLineIdle), receiver_enable_bit & cdN,
		transmitter_enable_bit & ctsN};
	assign rdData = rdPram ? pram_ff[rdIdx[4:0]]
		: rdBd ? bd_ff[rdIdx[BD_W+1:0]]
		: rdIdx == `UC_IDX_CTRL ? {12'h000, ctrl_ff}
		: rdIdx == `UC_IDX_EVENT ? {8'h00, evt_ff}
		: rdIdx == `UC_IDX_MASK ? {8'h00, mask_ff}
		: rdIdx == `UC_IDX_STATUS ? {8'h00, statusView} : 16'h0000;

	// Received character, bit 7 zeroed in 7-bit mode
	wire [7:0] rxData = ctrl_ff[`UC_CTL_CL8] ? rxChar.data : {1'b0, rxChar.data[6:0]};
	wire [4:0] bdBase = 5'({bdIdx_ff, 2'b00});
	wire [15:0] bdCtl = bd_ff[bdBase];
	wire [31:0] bdPtr = {bd_ff[bdBase + 5'd2], bd_ff[bdBase + 5'd3]};
	wire [15:0] lenInc = len_ff + 16'h0001;

	// ----------------------------------------
	// Control-character table search
	// ----------------------------------------
	logic [8:0] ccAlive;
	logic [7:0] ccHit;
	assign ccAlive[0] = 1'b1;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_cc
			wire [15:0] ent16 = pram_ff[`UC_PW_CHAR1 + 5'(gi)];
			assign ccAlive[gi+1] = ccAlive[gi] & ~ent16[`UC_CC_END];
			assign ccHit[gi] = ccAlive[gi+1] & ent16[7:0] == rxData;
		end
	endgenerate
	logic ccMatch, ccRej;
	always_comb begin
		ccMatch = 1'b0;
		ccRej = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			if (ccHit[i]) begin
				ccMatch = 1'b1;
				ccRej = pram_ff[`UC_PW_CHAR1 + 5'(i)][`UC_CC_REJ];
			end
		end
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	logic store, closeNow, closeC, closeId;
	logic [7:0] evtSet;
	logic [15:0] oosEnt;
	always_comb begin
		nxt_pram = pram_ff;
		nxt_bd = bd_ff;
		nxt_mask = mask_ff;
		nxt_ctrl = ctrl_ff;
		nxt_bdIdx = bdIdx_ff;
		nxt_len = len_ff;
		nxt_idle = idle_ff;
		nxt_acc = acc_ff;
		nxt_hunt = hunt_ff;
		nxt_oos = oos_ff;
		nxt_oosLost = oosLost_ff;
		nxt_bufWr = '0;
		evtSet = 8'h00;
		store = 1'b0;
		closeNow = 1'b0;
		closeC = 1'b0;
		closeId = 1'b0;
		oosEnt = pram_ff[`UC_PW_OOS];
		nxt_evt = evt_ff;
		// Software writes; hardware updates below take precedence
		if (wr.go) begin
			if (wrPram) nxt_pram[wr.idx[4:0]] = (pram_ff[wr.idx[4:0]] & ~laneMask)
				| (wr.data & laneMask);
			if (wrBd) nxt_bd[wr.idx[BD_W+1:0]] = (bd_ff[wr.idx[BD_W+1:0]] & ~laneMask)
				| (wr.data & laneMask);
			if (wr.idx == `UC_IDX_MASK && wr.strb[0]) nxt_mask = wr.data[7:0];
			if (wr.idx == `UC_IDX_CTRL && wr.strb[0]) nxt_ctrl = wr.data[3:0];
			if (wr.idx == `UC_IDX_EVENT && wr.strb[0]) nxt_evt = evt_ff & ~wr.data[7:0];
		end
		// Line change and sent-buffer events
		evtSet[`UC_EV_CD] = cdN != cdPrev_ff;
		evtSet[`UC_EV_CTS] = ctsN != ctsPrev_ff;
		evtSet[`UC_EV_IDL] = receiver_enable_bit & (rxLineIdle != idlPrev_ff);
		evtSet[`UC_EV_TX] = txBufDone & txBufIrq;
		if (receiver_enable_bit && cdN && len_ff != 16'h0000) nxt_acc[`UC_BD_CD] = 1'b1;
		if (receiver_enable_bit && rxChar.valid) begin
			nxt_idle = 16'h0000;
			if (rxChar.parityErr) nxt_pram[`UC_PW_PARC] = pram_ff[`UC_PW_PARC] + 16'h0001;
			if (rxChar.frameErr) nxt_pram[`UC_PW_FRMC] = pram_ff[`UC_PW_FRMC] + 16'h0001;
			if (rxChar.noise) nxt_pram[`UC_PW_NOISEC] = pram_ff[`UC_PW_NOISEC] + 16'h0001;
			if (rxChar.brk) begin
				nxt_pram[`UC_PW_BRKC] = pram_ff[`UC_PW_BRKC] + 16'h0001;
				evtSet[`UC_EV_BRK] = 1'b1;
				nxt_acc[`UC_BD_BR] = 1'b1;
			end else if (ctrl_ff[`UC_CTL_AUTOMD] && rxChar.isAddr) begin
				nxt_hunt = !(rxData == pram_ff[`UC_PW_ADDRA][7:0]
					|| rxData == pram_ff[`UC_PW_ADDRB][7:0]);
				if (!nxt_hunt) begin
					store = 1'b1;
					nxt_acc[`UC_BD_A] = 1'b1;
					nxt_acc[`UC_BD_M] = rxData == pram_ff[`UC_PW_ADDRA][7:0];
				end
			end else if (!(ctrl_ff[`UC_CTL_AUTOMD] && hunt_ff)) begin
				if (ccMatch && ccRej) begin
					nxt_pram[`UC_PW_RECEIVED_CONTROL_CHARACTER] = {8'h00, rxData};
					evtSet[`UC_EV_CCR] = 1'b1;
				end else begin
					store = 1'b1;
					closeC = ccMatch;
				end
			end
		end
		if (store && !bdCtl[`UC_BD_E]) begin
			evtSet[`UC_EV_BSY] = 1'b1;
			closeC = 1'b0;
		end else if (store) begin
			nxt_bufWr.valid = 1'b1;
			nxt_bufWr.extMem = bdCtl[`UC_BD_X];
			nxt_bufWr.addr = bdPtr + {16'h0000, len_ff};
			nxt_bufWr.data = rxData;
			nxt_len = lenInc;
			nxt_acc[`UC_BD_PR] = rxChar.parityErr;
			nxt_acc[`UC_BD_FR] = rxChar.frameErr;
			nxt_acc[`UC_BD_OV] = acc_ff[`UC_BD_OV] | rxChar.overrun;
			closeNow = closeC || lenInc >= pram_ff[`UC_PW_MRBL];
		end
		if (receiver_enable_bit && rxIdleChar && !rxChar.valid && len_ff != 16'h0000
			&& pram_ff[`UC_PW_IDLE] != 16'h0000) begin
			nxt_idle = idle_ff + 16'h0001;
			if (nxt_idle >= pram_ff[`UC_PW_IDLE]) begin
				closeNow = 1'b1;
				closeId = 1'b1;
			end
		end
		if (closeNow) begin
			nxt_bd[bdBase] = {1'b0, bdCtl[14:12], closeC, nxt_acc[10:9], closeId,
				2'b00, nxt_acc[5:3], 1'b0, nxt_acc[1:0]};
			nxt_bd[bdBase + 5'd1] = nxt_len;
			evtSet[`UC_EV_RX] = bdCtl[`UC_BD_I];
			// wrap back to the first descriptor
			nxt_bdIdx = bdCtl[`UC_BD_W] ? '0 : BD_W'(bdIdx_ff + 1'b1);
			nxt_len = 16'h0000;
			nxt_idle = 16'h0000;
			nxt_acc = 12'h000;
		end
		unique case (oos_ff)
			OOS_IDLE: begin
				if (transmitter_enable_bit && oosEnt[`UC_CC_END] && !oosEnt[`UC_CC_REJ] && oosEnt[`UC_CC_REA]) begin
					nxt_oos = OOS_SEND;
					nxt_oosLost = 1'b0;
				end
			end
			OOS_SEND: begin
				if (ctsN) nxt_oosLost = 1'b1;
				if (oosSent) begin
					nxt_oos = OOS_IDLE;
					nxt_pram[`UC_PW_OOS][`UC_CC_REA] = 1'b0;
					nxt_pram[`UC_PW_OOS][`UC_CC_CT] = oosLost_ff | ctsN;
					if (oosEnt[`UC_CC_INT]) evtSet[`UC_EV_TX] = 1'b1;
				end
			end
			default: nxt_oos = OOS_IDLE;
		endcase
		nxt_evt = nxt_evt | evtSet;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Storage arrays
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pram_ff <= '{default: 16'h0000};
			bd_ff <= '{default: 16'h0000};
		end else begin
			pram_ff <= nxt_pram;
			bd_ff <= nxt_bd;
		end
	end
	// Receive and event state
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			evt_ff <= 8'h00;
			mask_ff <= 8'h00;
			ctrl_ff <= 4'h0;
			bdIdx_ff <= '0;
			len_ff <= 16'h0000;
			idle_ff <= 16'h0000;
			acc_ff <= 12'h000;
			hunt_ff <= 1'b1;
			oos_ff <= OOS_IDLE;
			oosLost_ff <= 1'b0;
		end else begin
			evt_ff <= nxt_evt;
			mask_ff <= nxt_mask;
			ctrl_ff <= nxt_ctrl;
			bdIdx_ff <= nxt_bdIdx;
			len_ff <= nxt_len;
			idle_ff <= nxt_idle;
			acc_ff <= nxt_acc;
			hunt_ff <= nxt_hunt;
			oos_ff <= nxt_oos;
			oosLost_ff <= nxt_oosLost;
		end
	end
	// Output stage
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cdPrev_ff <= 1'b1;
			ctsPrev_ff <= 1'b1;
			idlPrev_ff <= 1'b0;
			bufWr_ff <= '0;
			breakReq_ff <= 1'b0;
			breakCnt_ff <= 16'h0000;
			irq_ff <= 1'b0;
			rxFc_ff <= 3'h0;
			txFc_ff <= 3'h0;
		end else begin
			cdPrev_ff <= cdN;
			ctsPrev_ff <= ctsN;
			idlPrev_ff <= receiver_enable_bit & rxLineIdle;
			bufWr_ff <= nxt_bufWr;
			breakReq_ff <= stopTxCmd;
			if (stopTxCmd) breakCnt_ff <= pram_ff[`UC_PW_BRK];
			irq_ff <= |(nxt_evt & nxt_mask);
			rxFc_ff <= pram_ff[`UC_PW_FCODE][14:12];
			txFc_ff <= pram_ff[`UC_PW_FCODE][6:4];
		end
	end
	assign bufWr = bufWr_ff;
	assign oosReq = '{valid: oos_ff == OOS_SEND, addrBit: oosEnt[`UC_CC_ADR], data: oosEnt[7:0]};
	assign breakReq = breakReq_ff;
	assign breakCount = breakCnt_ff;
	assign irqReq = irq_ff;
	assign rxFuncCode = rxFc_ff;
	assign txFuncCode = txFc_ff;
endmodule // uart_channel
`default_nettype wire

// ---- tb/uart_channel_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module uart_channel_checker import uart_chan_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic stopTxCmd,
	input wire logic breakReq,
	input wire logic [15:0] breakCount,
	input wire rx_char_t rxChar,
	input wire buf_wr_t bufWr,
	input wire oos_req_t oosReq,
	input wire logic oosSent,
	input wire logic s_bvalid,
	input wire logic [2:0] rxFuncCode,
	input wire logic [2:0] txFuncCode
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ----------------
	// Sequences
	// ----------------
	sequence brkAns;
		##1 breakReq;
	endsequence
	sequence oosDone;
		oosSent ##1 !oosReq.valid;
	endsequence
	// Break request follows the command
	breakPulse_a: assert property (stopTxCmd |-> brkAns)
		else $error("break request missing");
	breakOnce_a: assert property (breakReq |-> $past(stopTxCmd))
		else $error("break request without command");
	breakHold_a: assert property ($changed(breakCount) |-> breakReq)
		else $error("break count moved");
	// Buffer write needs a received byte
	bufCause_a: assert property (bufWr.valid |-> $past(rxChar.valid)
		&& bufWr.data == $past(rxChar.data)) else $error("stray buffer write");
	// Out-of-sequence request held until sent
	oosHold_a: assert property (oosReq.valid && !oosSent |=> oosReq.valid)
		else $error("request dropped early");
	oosDrop_a: assert property (oosReq.valid && oosSent |-> oosDone)
		else $error("request not released");
	oosData_a: assert property (oosReq.valid && $past(oosReq.valid)
		|-> $stable(oosReq.data) && $stable(oosReq.addrBit)) else $error("request data moved");
	// Function codes change only by a write
	fcodeWrite_a: assert property ($changed({rxFuncCode, txFuncCode})
		|-> s_bvalid || $past(s_bvalid)) else $error("function code moved");
endmodule // uart_channel_checker
bind uart_channel uart_channel_checker u_chk (.clk_sys, .rst_n, .stopTxCmd, .breakReq,
	.breakCount, .rxChar, .bufWr, .oosReq, .oosSent, .s_bvalid, .rxFuncCode, .txFuncCode);
`default_nettype wire

// ---- tb/serial_station.sv ----
`timescale 1ns/100ps
`default_nettype none
module serial_station import uart_chan_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [3:0] dly,
	input wire oos_req_t oosReq,
	output logic oosSent
);
	logic [3:0] cnt_ff;
	logic busy_ff;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 4'h0;
			busy_ff <= 1'b0;
			oosSent <= 1'b0;
		end else begin
			oosSent <= 1'b0;
			if (!oosReq.valid) begin
				busy_ff <= 1'b0;
			end else if (!busy_ff) begin
				if (cnt_ff == dly) begin
					oosSent <= 1'b1;
					busy_ff <= 1'b1;
					cnt_ff <= 4'h0;
				end else begin
					cnt_ff <= cnt_ff + 4'h1;
				end
			end
		end
	end
endmodule // serial_station
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "uart_chan_cfg.svh"
module testbench import uart_chan_pkg::*;;
	localparam logic [13:0] CT = `UC_IDX_CTRL;
	localparam logic [13:0] EV = `UC_IDX_EVENT;
	localparam logic [13:0] MK = `UC_IDX_MASK;
	localparam logic [13:0] ST = `UC_IDX_STATUS;
	localparam logic [13:0] PR = `UC_IDX_PRAM;
	localparam logic [13:0] BD = `UC_IDX_BD;
	typedef struct packed {logic [13:0] i; logic [15:0] d; logic [15:0] e;} row_t;
	row_t rows [4] = '{'{MK, 16'hffff, 16'h00ff}, '{PR + 14'd14, 16'h1234, 16'h1234},
		'{PR + 14'd20, 16'h00a1, 16'h00a1}, '{PR + 14'd21, 16'h00b2, 16'h00b2}};
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] s_awaddr = 16'h0000;
	logic [15:0] s_araddr = 16'h0000;
	logic [31:0] s_wdata = 32'h00000000;
	logic [3:0] s_wstrb = 4'h3;
	logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, oosSent, breakReq, irqReq;
	logic [1:0] s_bresp, s_rresp, rsp;
	logic [31:0] s_rdata;
	logic cdPin_n = 1'b1, ctsPin_n = 1'b1, rxIdleChar = 1'b0, rxLineIdle = 1'b0;
	logic txBufDone = 1'b0, txBufIrq = 1'b0, stopTxCmd = 1'b0;
	logic [3:0] dly = 4'h0;
	logic [15:0] breakCount, rv;
	logic [2:0] rxFuncCode, txFuncCode;
	logic [8:0] pv = 9'b110_001_000;
	rx_char_t rxChar = '0;
	buf_wr_t bufWr, seen;
	oos_req_t oosReq;
	int miscompares = 0;
	int comparisons = 0;
	// ----------------
	// Clock and instances
	// ----------------
	always #25 clk_sys = ~clk_sys;
	uart_channel u_uart_channel (.clk_sys, .rst_n, .s_awaddr, .s_awvalid, .s_awready,
		.s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
		.s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
		.cdPin_n, .ctsPin_n, .rxChar, .rxIdleChar, .rxLineIdle, .txBufDone, .txBufIrq,
		.stopTxCmd, .oosSent, .bufWr, .oosReq, .breakReq, .breakCount, .rxFuncCode,
		.txFuncCode, .irqReq);
	serial_station u_serial_station (.clk_sys, .rst_n, .dly, .oosReq, .oosSent);
	// ----------------
	// Tasks
	// ----------------
	task automatic chk(input logic [47:0] s, input logic [47:0] e);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [13:0] i, input logic [15:0] d);
		@(posedge clk_sys);
		s_awaddr <= {i, 2'b00};
		s_wdata <= {16'h0000, d};
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
		end while (!s_bvalid);
		rsp = s_bresp;
		s_bready <= 1'b0;
	endtask
	task automatic rdchk(input logic [13:0] i, input logic [15:0] m, input logic [15:0] e);
		@(posedge clk_sys);
		s_araddr <= {i, 2'b00};
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_arready) s_arvalid <= 1'b0;
		end while (!s_rvalid);
		rv = s_rdata[15:0];
		s_rready <= 1'b0;
		chk(rv & m, e);
	endtask
	task automatic rxc(input logic [7:0] d, input logic [4:0] f);
		@(posedge clk_sys);
		rxChar <= {1'b1, d, 1'b0, f};
		@(posedge clk_sys);
		rxChar <= '0;
		#1;
		seen = bufWr;
	endtask
	task automatic stop_test;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ----------------
	// Main sequence
	// ----------------
	initial begin
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		foreach (rows[k]) begin
			wr(rows[k].i, rows[k].d);
			rdchk(rows[k].i, 16'hffff, rows[k].e);
		end
		rdchk(ST, 16'hffff, 16'h0000);
		wr(14'h0001, 16'h0000);
		chk(rsp, 2'b10);
		wr(PR, 16'h6050);
		@(posedge clk_sys);
		#1 chk({rxFuncCode, txFuncCode}, 6'o65);
		// Table, descriptor and enables
		wr(PR + 14'd1, 16'h0003);
		wr(PR + 14'd23, 16'h407e);
		wr(PR + 14'd24, 16'h8000);
		wr(PR + 14'd25, 16'h0055);
		wr(BD + 14'd3, 16'h1000);
		wr(BD, 16'hb000);
		wr(MK, 16'h000f);
		wr(CT, 16'h000b);
		rxc(8'h21, 5'b00010);
		chk(seen.valid, 1'b0);
		rxc(8'h7e, 5'b00000);
		chk(seen.valid, 1'b0);
		rdchk(PR + 14'd22, 16'hffff, 16'h007e);
		rdchk(EV, 16'h0008, 16'h0008);
		rxc(8'h41, 5'b11100);
		chk({seen.valid, seen.addr, seen.data}, {1'b1, 32'h1000, 8'h41});
		rxc(8'h55, 5'b00000);
		chk({seen.valid, seen.addr, seen.data}, {1'b1, 32'h1001, 8'h55});
		rxc(8'h42, 5'b00000);
		chk({seen.valid, seen.addr, seen.data}, {1'b1, 32'h1002, 8'h42});
		rdchk(BD + 14'd1, 16'hffff, 16'h0003);
		rdchk(BD, 16'h8000, 16'h0000);
		rdchk(EV, 16'h0009, 16'h0009);
		chk(irqReq, 1'b1);
		for (int k = 16; k < 20; k++) rdchk(PR + 14'(k), 16'hffff, 16'h0001);
		wr(EV, 16'h00ff);
		rdchk(EV, 16'hffff, 16'h0000);
		chk(irqReq, 1'b0);
		rxc(8'h43, 5'b00000);
		chk(seen.valid, 1'b0);
		rdchk(EV, 16'h0004, 16'h0004);
		// Idle characters close a buffer that holds data
		wr(PR + 14'd14, 16'h0002);
		wr(BD, 16'h9000);
		rxc(8'h44, 5'b00000);
		repeat (2) begin
			@(posedge clk_sys);
			rxIdleChar <= 1'b1;
			@(posedge clk_sys);
			rxIdleChar <= 1'b0;
		end
		rdchk(BD, 16'h8100, 16'h0100);
		wr(MK, 16'h0000);
		@(posedge clk_sys);
		#1 chk(irqReq, 1'b0);
		wr(EV, 16'h00ff);
		// Transmit buffer and out-of-sequence events
		for (int j = 0; j < 2; j++) begin
			@(posedge clk_sys);
			txBufDone <= 1'b1;
			txBufIrq <= j[0];
			@(posedge clk_sys);
			txBufDone <= 1'b0;
			rdchk(EV, 16'h0002, 16'(j * 2));
			wr(EV, 16'h00ff);
			dly <= 4'(j * 6);
			wr(PR + 14'd30, 16'hb113);
			for (int k = 0; k < 30 && oosReq.valid !== 1'b1; k++) @(posedge clk_sys);
			chk({oosReq.valid, oosReq.addrBit, oosReq.data}, {2'b11, 8'h13});
			for (int k = 0; k < 30 && oosReq.valid; k++) @(posedge clk_sys);
			rdchk(PR + 14'd30, 16'h2000, 16'h0000);
			rdchk(EV, 16'h0002, 16'h0002);
			wr(EV, 16'h00ff);
		end
		// Live line status
		for (int j = 0; j < 3; j++) begin
			{cdPin_n, ctsPin_n, rxLineIdle} <= pv[8 - 3 * j -: 3];
			repeat (5) @(posedge clk_sys);
			rdchk(ST, 16'h0007, {13'h0, cdPin_n | rxLineIdle, cdPin_n, ctsPin_n});
		end
		wr(PR + 14'd15, 16'h0003);
		@(posedge clk_sys);
		stopTxCmd <= 1'b1;
		@(posedge clk_sys);
		stopTxCmd <= 1'b0;
		#1 chk({breakReq, breakCount}, {1'b1, 16'h0003});
		// Second reset clears the registers
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		rdchk(MK, 16'hffff, 16'h0000);
		rdchk(PR + 14'd15, 16'hffff, 16'h0000);
		stop_test;
	end
	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		stop_test;
	end
endmodule // testbench
`default_nettype wire
